// ### rtl/vswc_pkg.sv
// shared constants, types and helpers of the video switch configuration bank
package vswc_pkg;

	// register offsets on the serial control register port
	localparam logic [7:0] VSWC_OFS_FAST_MODES = 8'h00;
	localparam logic [7:0] VSWC_OFS_AUX_MODES = 8'h01;
	localparam logic [7:0] VSWC_OFS_RX_SETTINGS = 8'h10;
	localparam logic [7:0] VSWC_OFS_PULSE_AB = 8'h11;
	localparam logic [7:0] VSWC_OFS_PULSE_CD = 8'h12;
	localparam logic [7:0] VSWC_OFS_EQ_AB = 8'h13;
	localparam logic [7:0] VSWC_OFS_EQ_CD = 8'h14;
	localparam logic [7:0] VSWC_OFS_TX_SETTINGS = 8'h20;

	// reset values
	localparam logic [7:0] VSWC_RST_FAST_MODES = 8'h40;
	localparam logic [7:0] VSWC_RST_AUX_MODES = 8'h40;
	localparam logic [7:0] VSWC_RST_RX_SETTINGS = 8'h01;
	localparam logic [7:0] VSWC_RST_PULSE = 8'h00;
	localparam logic [7:0] VSWC_RST_EQ = 8'h00;
	localparam logic [7:0] VSWC_RST_TX_SETTINGS = 8'h03;
	localparam logic [7:0] VSWC_RDATA_UNMAPPED = 8'h00;

	// writable bit masks; reserved bits store and read zero
	localparam logic [7:0] VSWC_MASK_MODES = 8'h43;
	localparam logic [7:0] VSWC_MASK_RX = 8'h01;
	localparam logic [7:0] VSWC_MASK_TX = 8'h0f;
	localparam logic [7:0] VSWC_MASK_ALL = 8'hff;

	// field positions
	localparam int VSWC_ENABLE_BIT = 6;
	localparam int VSWC_SEL_LSB = 0;
	localparam int VSWC_SEL_MSB = 1;
	localparam int VSWC_TERM_ON_BIT = 0;
	localparam int VSWC_PE_LSB = 2;
	localparam int VSWC_PE_MSB = 3;
	localparam int VSWC_OTERM_BIT = 1;
	localparam int VSWC_OCUR_BIT = 0;

	// source codes of the two-bit select fields
	localparam logic [1:0] VSWC_SRC_A = 2'h0;
	localparam logic [1:0] VSWC_SRC_B = 2'h1;
	localparam logic [1:0] VSWC_SRC_C = 2'h2;
	localparam logic [1:0] VSWC_SRC_D = 2'h3;

	// termination pulse timing
	localparam int VSWC_PULSE_TIME_MS = 100;
	localparam int VSWC_CLK_FREQ_HZ = 200_000_000;
	localparam int VSWC_PULSE_CYCLES = VSWC_PULSE_TIME_MS * (VSWC_CLK_FREQ_HZ / 1000);
	localparam int VSWC_PULSE_CNT_W = 25;

	// pulse timer states
	typedef enum logic [0:0] {
		VSWC_TP_IDLE = 1'b0,
		VSWC_TP_OPEN = 1'b1
	} vswc_tp_state_t;

	// vector bit that serves channel ch of source src
	function automatic int vswc_chan_bit(input logic [1:0] src, input int ch);
		int idx;
		idx = 0;
		unique case (src)
			VSWC_SRC_B: idx = ch;
			VSWC_SRC_A: idx = 4 + ch;
			VSWC_SRC_C: idx = 8 + (3 - ch);
			VSWC_SRC_D: idx = 12 + (3 - ch);
		endcase
		return idx;
	endfunction : vswc_chan_bit

	// one-hot route of a select field, all zero when disabled
	function automatic logic [3:0] vswc_route(input logic [1:0] sel, input logic en);
		logic [3:0] r;
		r = 4'h0;
		if (en) begin
			r[sel] = 1'b1;
		end
		return r;
	endfunction : vswc_route

endpackage : vswc_pkg

// ### rtl/vswc_chan_map.sv
// splits a sixteen-bit per-channel vector into four per-source nibbles
`timescale 1ns/10ps
module vswc_chan_map (
	// packed per-channel vector
	input wire logic [15:0] vec_i,
	// per-source channel bits, index is channel number
	output logic [3:0] src_a_o,
	output logic [3:0] src_b_o,
	output logic [3:0] src_c_o,
	output logic [3:0] src_d_o
);
	import vswc_pkg::*;

	// pure rewiring of the scrambled bit order
	always_comb begin
		for (int ch = 0; ch < 4; ch++) begin
			src_a_o[ch] = vec_i[vswc_chan_bit(VSWC_SRC_A, ch)];
			src_b_o[ch] = vec_i[vswc_chan_bit(VSWC_SRC_B, ch)];
			src_c_o[ch] = vec_i[vswc_chan_bit(VSWC_SRC_C, ch)];
			src_d_o[ch] = vec_i[vswc_chan_bit(VSWC_SRC_D, ch)];
		end
	end

endmodule : vswc_chan_map

// ### rtl/vswc_term_pulse.sv
// times the termination disconnect window after a source change
`timescale 1ns/10ps
module vswc_term_pulse #(
	parameter int PULSE_CYCLES = vswc_pkg::VSWC_PULSE_CYCLES
) (
	// clock and reset
	input wire logic sys_clk_i,
	input wire logic rst_i,
	// effective fast source select
	input wire logic [1:0] source_select_i,
	// high while the disconnect window runs
	output logic open_o
);
	import vswc_pkg::*;

	localparam logic [VSWC_PULSE_CNT_W-1:0] LOAD = VSWC_PULSE_CNT_W'(PULSE_CYCLES - 1);

	vswc_tp_state_t state_reg, state_next; // window state
	logic [VSWC_PULSE_CNT_W-1:0] cnt_reg, cnt_next; // cycles left in window
	logic [1:0] sel_reg, sel_next; // last seen select

	// next state: a change restarts the window, else count down
	always_comb begin
		state_next = state_reg;
		cnt_next = cnt_reg;
		sel_next = source_select_i;
		if (source_select_i != sel_reg) begin
			// restart on every change, even inside a window
			state_next = VSWC_TP_OPEN;
			cnt_next = LOAD;
		end else begin
			unique case (state_reg)
				VSWC_TP_IDLE: begin
					cnt_next = cnt_reg;
				end
				VSWC_TP_OPEN: begin
					if (cnt_reg == '0) begin
						state_next = VSWC_TP_IDLE;
					end else begin
						cnt_next = cnt_reg - 1'b1;
					end
				end
			endcase
		end
	end

	// registers; select reset matches the register reset source
	always_ff @(posedge sys_clk_i or posedge rst_i) begin
		if (rst_i) begin
			state_reg <= VSWC_TP_IDLE;
			cnt_reg <= '0;
			sel_reg <= VSWC_SRC_A;
		end else begin
			state_reg <= state_next;
			cnt_reg <= cnt_next;
			sel_reg <= sel_next;
		end
	end

	assign open_o = (state_reg == VSWC_TP_OPEN);

endmodule : vswc_term_pulse

// ### rtl/vswc_config_regs.sv
// configuration register bank of the four-to-one video link switch
// What this block does
// - aux select 00..11 routes aux A..D
// - input termination bit off disconnects all
// - pulse bit set: termination off 100 ms
// - pulse bit clear: termination stays connected
// - per-channel bit order B, A, C reversed, D reversed
// - equalization bit: 0 low, 1 high
// - pre-emphasis field sets all outputs together
// - output termination bit: 0 off, 1 on
// - current bit: 0 10 mA, 1 20 mA
// - straps govern until first serial access
// - straps drive enable, select, eq, tx settings
// - straps: aux enabled, aux select from source pins
// - straps force input termination on
// - straps force all pulse bits zero
// - strap eq pin copied to all sixteen bits
// - mode register: enable bit6, select bits1:0
// - fast enable 0 standby, 1 active
// - fast select 00..11 routes source A..D
// - aux enable 0 disconnects aux switch
`timescale 1ns/10ps
module vswc_config_regs #(
	parameter int PULSE_CYCLES = vswc_pkg::VSWC_PULSE_CYCLES
) (
	// clock and reset
	input wire logic sys_clk_i,
	input wire logic rst_i,
	// register port from the serial control interface
	input wire logic reg_wr_i,
	input wire logic reg_rd_i,
	input wire logic [7:0] reg_addr_i,
	input wire logic [7:0] reg_wdata_i,
	output logic [7:0] reg_rdata_o,
	// strap pins
	input wire logic strap_fast_enable_i,
	input wire logic [1:0] strap_source_select_i,
	input wire logic strap_equalization_i,
	input wire logic [1:0] strap_preemphasis_field_i,
	input wire logic strap_output_termination_i,
	input wire logic strap_output_current_i,
	// mode indication
	output logic strap_mode_o,
	// fast switch controls
	output logic fast_channel_enable_o,
	output logic [1:0] fast_source_select_o,
	output logic [3:0] fast_route_o,
	// low speed switch controls
	output logic low_speed_enable_o,
	output logic [1:0] low_speed_source_select_o,
	output logic [3:0] low_speed_common_port_o,
	// input termination per source, index is channel
	output logic [3:0] input_termination_a_o,
	output logic [3:0] input_termination_b_o,
	output logic [3:0] input_termination_c_o,
	output logic [3:0] input_termination_d_o,
	// equalization level per source, 1 is high
	output logic [3:0] input_equalization_level_a_o,
	output logic [3:0] input_equalization_level_b_o,
	output logic [3:0] input_equalization_level_c_o,
	output logic [3:0] input_equalization_level_d_o,
	// transmitter controls for all outputs
	output logic [1:0] output_preemphasis_level_o,
	output logic output_termination_on_o,
	output logic output_current_level_o
);
	import vswc_pkg::*;

	// one byte per mapped offset; reserved bits
	// are held at zero by the write masks, so a
	// read returns exactly what the fields drive
	// straps are copied once, at the first edge
	// after release, never sampled continuously
	// a strobe standing at that edge skips the copy
	// after that only serial writes move the bank
	// terminations pass one flip-flop, so the
	// analog switches see no decode glitches
	// serial bank registers
	logic [7:0] fast_modes_reg, fast_modes_next; // fast enable and select
	logic [7:0] aux_modes_reg, aux_modes_next; // aux enable and select
	logic [7:0] rx_settings_reg, rx_settings_next; // input termination on
	logic [7:0] pulse_ab_reg, pulse_ab_next; // pulse bits 7:0
	logic [7:0] pulse_cd_reg, pulse_cd_next; // pulse bits 15:8
	logic [7:0] eq_ab_reg, eq_ab_next; // eq bits 7:0
	logic [7:0] eq_cd_reg, eq_cd_next; // eq bits 15:8
	logic [7:0] tx_settings_reg, tx_settings_next; // transmitter settings
	// control hand-over
	logic strap_mode_reg, strap_mode_next; // straps still govern
	logic captured_reg, captured_next; // first edge after release passed, straps copied or skipped
	// read path
	logic [7:0] rdata_reg, rdata_next; // read data
	// termination path
	logic [15:0] term_reg, term_next; // effective terminations, packed
	logic [15:0] pulse_vec; // packed pulse bits
	logic [15:0] eq_vec; // packed eq bits
	// per-source bits after unscrambling
	logic [3:0] pa, pb, pc, pd; // pulse bits per source
	logic [3:0] ta, tb, tc, td; // termination per source
	// window and strobe flags
	logic pulse_open; // disconnect window running
	logic access; // any serial access this cycle

	// any strobe, mapped address or not, is
	// the access that ends strap control
	assign access = reg_wr_i | reg_rd_i;
	// upper byte of each vector is the second register
	assign pulse_vec = {pulse_cd_reg, pulse_ab_reg};
	assign eq_vec = {eq_cd_reg, eq_ab_reg};

	// register next values: strap capture, then serial writes
	// the copy takes only the first edge, and only if no strobe stands there
	// a write overrides one register at any later edge
	// read and write together: the read sees the
	// value from before the write
	always_comb begin
		fast_modes_next = fast_modes_reg;
		aux_modes_next = aux_modes_reg;
		rx_settings_next = rx_settings_reg;
		pulse_ab_next = pulse_ab_reg;
		pulse_cd_next = pulse_cd_reg;
		eq_ab_next = eq_ab_reg;
		eq_cd_next = eq_cd_reg;
		tx_settings_next = tx_settings_reg;
		// capture is armed for one edge only
		captured_next = 1'b1;
		strap_mode_next = strap_mode_reg;
		if (!captured_reg && !access) begin
			// first edge after release: load the straps into the bank
			// fast modes: strap enable and select
			fast_modes_next = '0;
			fast_modes_next[VSWC_ENABLE_BIT] = strap_fast_enable_i;
			fast_modes_next[VSWC_SEL_MSB:VSWC_SEL_LSB] = strap_source_select_i;
			// aux switch on, select shared with fast
			aux_modes_next = '0;
			aux_modes_next[VSWC_ENABLE_BIT] = 1'b1;
			aux_modes_next[VSWC_SEL_MSB:VSWC_SEL_LSB] = strap_source_select_i;
			// receiver: terminations fixed on
			rx_settings_next = '0;
			rx_settings_next[VSWC_TERM_ON_BIT] = 1'b1;
			// straps pulse no channel
			pulse_ab_next = '0;
			pulse_cd_next = '0;
			// one equalization level for all channels
			eq_ab_next = {8{strap_equalization_i}};
			eq_cd_next = {8{strap_equalization_i}};
			// transmitter fields straight from pins
			tx_settings_next = '0;
			tx_settings_next[VSWC_PE_MSB:VSWC_PE_LSB] = strap_preemphasis_field_i;
			tx_settings_next[VSWC_OTERM_BIT] = strap_output_termination_i;
			tx_settings_next[VSWC_OCUR_BIT] = strap_output_current_i;
		end
		if (access) begin
			// first serial access hands control to the serial registers
			strap_mode_next = 1'b0;
		end
		// a write lands on the edge that takes it
		if (reg_wr_i) begin
			// reserved bits are masked to zero on write
			unique case (reg_addr_i)
				VSWC_OFS_FAST_MODES: fast_modes_next = reg_wdata_i & VSWC_MASK_MODES;
				VSWC_OFS_AUX_MODES: aux_modes_next = reg_wdata_i & VSWC_MASK_MODES;
				VSWC_OFS_RX_SETTINGS: rx_settings_next = reg_wdata_i & VSWC_MASK_RX;
				VSWC_OFS_PULSE_AB: pulse_ab_next = reg_wdata_i & VSWC_MASK_ALL;
				VSWC_OFS_PULSE_CD: pulse_cd_next = reg_wdata_i & VSWC_MASK_ALL;
				VSWC_OFS_EQ_AB: eq_ab_next = reg_wdata_i & VSWC_MASK_ALL;
				VSWC_OFS_EQ_CD: eq_cd_next = reg_wdata_i & VSWC_MASK_ALL;
				VSWC_OFS_TX_SETTINGS: tx_settings_next = reg_wdata_i & VSWC_MASK_TX;
				default: fast_modes_next = fast_modes_reg; // unmapped write ignored
			endcase
		end
	end

	// read data mux, registered; unmapped offsets read zero
	// data stands from the edge after the strobe
	// until the next read, so the host may take
	// it at any later edge before the next read
	always_comb begin
		// hold the last data between reads
		rdata_next = rdata_reg;
		if (reg_rd_i) begin
			unique case (reg_addr_i)
				VSWC_OFS_FAST_MODES: rdata_next = fast_modes_reg;
				VSWC_OFS_AUX_MODES: rdata_next = aux_modes_reg;
				VSWC_OFS_RX_SETTINGS: rdata_next = rx_settings_reg;
				VSWC_OFS_PULSE_AB: rdata_next = pulse_ab_reg;
				VSWC_OFS_PULSE_CD: rdata_next = pulse_cd_reg;
				VSWC_OFS_EQ_AB: rdata_next = eq_ab_reg;
				VSWC_OFS_EQ_CD: rdata_next = eq_cd_reg;
				VSWC_OFS_TX_SETTINGS: rdata_next = tx_settings_reg;
				default: rdata_next = VSWC_RDATA_UNMAPPED;
			endcase
		end
	end

	// unscramble the pulse vector per source
	// wires only: a write lands with no delay
	vswc_chan_map u_pulse_map (
		.vec_i(pulse_vec),
		.src_a_o(pa),
		.src_b_o(pb),
		.src_c_o(pc),
		.src_d_o(pd)
	);

	// unscramble the equalization vector per source
	// levels reach the equalizers through wires
	vswc_chan_map u_eq_map (
		.vec_i(eq_vec),
		.src_a_o(input_equalization_level_a_o),
		.src_b_o(input_equalization_level_b_o),
		.src_c_o(input_equalization_level_c_o),
		.src_d_o(input_equalization_level_d_o)
	);

	// disconnect window after each fast source change
	// it watches the registered select, so a
	// strap copy with a non-zero select opens a
	// window too; strap pulse bits are zero then
	// so no channel drops
	vswc_term_pulse #(
		.PULSE_CYCLES(PULSE_CYCLES)
	) u_term_pulse (
		.sys_clk_i(sys_clk_i),
		.rst_i(rst_i),
		.source_select_i(fast_modes_reg[VSWC_SEL_MSB:VSWC_SEL_LSB]),
		.open_o(pulse_open)
	);

	// effective termination: global on, minus pulsed channels in a window
	// a clear receiver bit wins over everything
	// a pulse bit only matters while the window
	// runs; channels with a clear pulse bit
	// stay connected across every switch
	always_comb begin
		ta = {4{rx_settings_reg[VSWC_TERM_ON_BIT]}} & ~({4{pulse_open}} & pa);
		tb = {4{rx_settings_reg[VSWC_TERM_ON_BIT]}} & ~({4{pulse_open}} & pb);
		tc = {4{rx_settings_reg[VSWC_TERM_ON_BIT]}} & ~({4{pulse_open}} & pc);
		td = {4{rx_settings_reg[VSWC_TERM_ON_BIT]}} & ~({4{pulse_open}} & pd);
		// pack d down to a, channel order kept
		term_next = {td, tc, tb, ta};
	end

	// all bank state; reset loads the bank defaults before strap capture
	// reset shows defaults, not straps; terminations
	// stay off until the first edges after release
	always_ff @(posedge sys_clk_i or posedge rst_i) begin
		if (rst_i) begin
			fast_modes_reg <= VSWC_RST_FAST_MODES;
			aux_modes_reg <= VSWC_RST_AUX_MODES;
			rx_settings_reg <= VSWC_RST_RX_SETTINGS;
			pulse_ab_reg <= VSWC_RST_PULSE;
			pulse_cd_reg <= VSWC_RST_PULSE;
			eq_ab_reg <= VSWC_RST_EQ;
			eq_cd_reg <= VSWC_RST_EQ;
			tx_settings_reg <= VSWC_RST_TX_SETTINGS;
			// straps govern until the first access
			strap_mode_reg <= 1'b1;
			captured_reg <= 1'b0;
			rdata_reg <= VSWC_RDATA_UNMAPPED;
			// terminations off while in reset
			term_reg <= '0;
		end else begin
			// every register loads on every edge
			fast_modes_reg <= fast_modes_next;
			aux_modes_reg <= aux_modes_next;
			rx_settings_reg <= rx_settings_next;
			pulse_ab_reg <= pulse_ab_next;
			pulse_cd_reg <= pulse_cd_next;
			eq_ab_reg <= eq_ab_next;
			eq_cd_reg <= eq_cd_next;
			tx_settings_reg <= tx_settings_next;
			strap_mode_reg <= strap_mode_next;
			captured_reg <= captured_next;
			rdata_reg <= rdata_next;
			term_reg <= term_next;
		end
	end

	// outputs straight from the bank
	// register port and mode flag
	assign reg_rdata_o = rdata_reg;
	assign strap_mode_o = strap_mode_reg;
	// fast switch
	assign fast_channel_enable_o = fast_modes_reg[VSWC_ENABLE_BIT];
	assign fast_source_select_o = fast_modes_reg[VSWC_SEL_MSB:VSWC_SEL_LSB];
	assign fast_route_o = vswc_route(fast_source_select_o, fast_channel_enable_o);
	// low speed switch
	assign low_speed_enable_o = aux_modes_reg[VSWC_ENABLE_BIT];
	assign low_speed_source_select_o = aux_modes_reg[VSWC_SEL_MSB:VSWC_SEL_LSB];
	assign low_speed_common_port_o = vswc_route(low_speed_source_select_o, low_speed_enable_o);
	// terminations, one flop behind the cause
	assign input_termination_a_o = term_reg[3:0];
	assign input_termination_b_o = term_reg[7:4];
	assign input_termination_c_o = term_reg[11:8];
	assign input_termination_d_o = term_reg[15:12];
	// transmitter, shared by all outputs
	assign output_preemphasis_level_o = tx_settings_reg[VSWC_PE_MSB:VSWC_PE_LSB];
	assign output_termination_on_o = tx_settings_reg[VSWC_OTERM_BIT];
	assign output_current_level_o = tx_settings_reg[VSWC_OCUR_BIT];

endmodule : vswc_config_regs

// ### sim/vswc_config_regs_sva.sv
// checker of the register port and decoded controls of the configuration bank
`timescale 1ns/10ps
module vswc_config_regs_sva (
	// clock and reset
	input wire logic sys_clk_i,
	input wire logic rst_i,
	// register port
	input wire logic reg_wr_i,
	input wire logic reg_rd_i,
	input wire logic [7:0] reg_addr_i,
	input wire logic [7:0] reg_wdata_i,
	input wire logic [7:0] reg_rdata_o,
	// decoded controls
	input wire logic strap_mode_o,
	input wire logic fast_channel_enable_o,
	input wire logic [1:0] fast_source_select_o,
	input wire logic [3:0] fast_route_o,
	input wire logic low_speed_enable_o,
	input wire logic [1:0] low_speed_source_select_o,
	input wire logic [3:0] low_speed_common_port_o,
	input wire logic [3:0] input_termination_b_o,
	input wire logic [1:0] output_preemphasis_level_o,
	input wire logic output_termination_on_o,
	input wire logic output_current_level_o
);
	import vswc_pkg::*;
	// one domain, so clock and reset are given once
	default clocking cb @(posedge sys_clk_i); endclocking
	default disable iff (rst_i);
	// any strobe hands control to the serial registers
	a_strap_mode_end: assert property ((reg_wr_i || reg_rd_i) |=> !strap_mode_o)
		else $error("strap mode kept after an access");
	// with no strobe strap control persists
	a_strap_mode_hold: assert property (strap_mode_o && !reg_wr_i && !reg_rd_i |=> strap_mode_o)
		else $error("strap mode ended without an access");
	// straps keep the aux switch on and share the fast select
	a_strap_aux_follow: assert property (strap_mode_o |-> low_speed_enable_o &&
		(low_speed_source_select_o == fast_source_select_o))
		else $error("aux settings differ from straps");
	// mode register field placement
	a_mode_write_apply: assert property (reg_wr_i && reg_addr_i == VSWC_OFS_FAST_MODES |=>
		fast_channel_enable_o == $past(reg_wdata_i[6]) && fast_source_select_o == $past(reg_wdata_i[1:0]))
		else $error("mode write not applied");
	// transmitter field placement
	a_tx_write_apply: assert property (reg_wr_i && reg_addr_i == VSWC_OFS_TX_SETTINGS |=>
		{output_preemphasis_level_o, output_termination_on_o, output_current_level_o} == $past(reg_wdata_i[3:0]))
		else $error("tx write not applied");
	// tx read returns the live fields one cycle later
	a_tx_read_data: assert property (reg_rd_i && !reg_wr_i && reg_addr_i == VSWC_OFS_TX_SETTINGS |=>
		reg_rdata_o == {4'h0, $past(output_preemphasis_level_o), $past(output_termination_on_o),
		$past(output_current_level_o)})
		else $error("tx read data wrong");
	// fast route is one-hot of the select, empty when off
	a_fast_route_map: assert property (fast_route_o == (fast_channel_enable_o ? 4'h1 << fast_source_select_o : 4'h0))
		else $error("fast route wrong");
	// aux common port is one-hot of the aux select, empty when off
	a_aux_route_map: assert property (low_speed_common_port_o ==
		(low_speed_enable_o ? 4'h1 << low_speed_source_select_o : 4'h0))
		else $error("aux route wrong");
	// clearing the input termination bit drops the source B terminations
	a_rx_term_off: assert property (reg_wr_i && reg_addr_i == VSWC_OFS_RX_SETTINGS && !reg_wdata_i[0] |->
		##2 input_termination_b_o == 4'h0)
		else $error("termination stayed on");
endmodule : vswc_config_regs_sva

bind vswc_config_regs vswc_config_regs_sva u_sva (.sys_clk_i, .rst_i, .reg_wr_i, .reg_rd_i, .reg_addr_i,
	.reg_wdata_i, .reg_rdata_o, .strap_mode_o, .fast_channel_enable_o, .fast_source_select_o, .fast_route_o,
	.low_speed_enable_o, .low_speed_source_select_o, .low_speed_common_port_o, .input_termination_b_o,
	.output_preemphasis_level_o, .output_termination_on_o, .output_current_level_o);

// ### sim/vswc_strap_host.sv
// strap pin levels tied as a board would tie them
`timescale 1ns/10ps
module vswc_strap_host #(
	parameter logic EN = 1'b1,
	parameter logic [1:0] SEL = 2'h2,
	parameter logic EQ = 1'b1,
	parameter logic [1:0] PE = 2'h1,
	parameter logic OTO = 1'b0,
	parameter logic OCL = 1'b1
) (
	// strap levels
	output logic en_o,
	output logic [1:0] sel_o,
	output logic eq_o,
	output logic [1:0] pe_o,
	output logic oto_o,
	output logic ocl_o
);
	// tied pins never move
	assign en_o = EN;
	assign sel_o = SEL;
	assign eq_o = EQ;
	assign pe_o = PE;
	assign oto_o = OTO;
	assign ocl_o = OCL;
endmodule : vswc_strap_host

// ### sim/tb_vswc_config_regs.sv
// self-checking bench of the configuration register bank
`timescale 1ns/10ps
module tb_vswc_config_regs;
	import vswc_pkg::*;
	localparam int PULSE_N = 20;
	// strap levels, shared with the pin model
	localparam logic S_EN = 1'b0;
	localparam logic [1:0] S_SEL = 2'h2;
	localparam logic S_EQ = 1'b1;
	localparam logic [1:0] S_PE = 2'h1;
	localparam logic S_OTO = 1'b0;
	localparam logic S_OCL = 1'b1;
	// register table: offset, reset value, writable mask
	logic [7:0] ofs [8] = '{8'h00, 8'h01, 8'h10, 8'h11, 8'h12, 8'h13, 8'h14, 8'h20};
	logic [7:0] rvl [8] = '{8'h40, 8'h40, 8'h01, 8'h00, 8'h00, 8'h00, 8'h00, 8'h03};
	logic [7:0] msk [8] = '{8'h43, 8'h43, 8'h01, 8'hff, 8'hff, 8'hff, 8'hff, 8'h0f};
	logic sys_clk_i, rst_i, reg_wr_i, reg_rd_i, s_en, s_eq, s_oto, s_ocl;
	logic strap_mode, fen, len, oterm, ocur;
	logic [1:0] s_sel, s_pe, fsel, lsel, pe;
	logic [7:0] reg_addr_i, reg_wdata_i, reg_rdata_o;
	logic [3:0] froute, lport, term_a, term_b, term_c, term_d, eq_a, eq_b, eq_c, eq_d;
	int error_cnt = 0;
	int num_checks = 0;
	int cycle_cnt = 0;
	// pin model and device
	vswc_strap_host #(.EN(S_EN), .SEL(S_SEL), .EQ(S_EQ), .PE(S_PE), .OTO(S_OTO), .OCL(S_OCL)) u_straps (
		.en_o(s_en), .sel_o(s_sel), .eq_o(s_eq), .pe_o(s_pe), .oto_o(s_oto), .ocl_o(s_ocl));
	vswc_config_regs #(.PULSE_CYCLES(PULSE_N)) dut (.sys_clk_i(sys_clk_i), .rst_i(rst_i), .reg_wr_i(reg_wr_i),
		.reg_rd_i(reg_rd_i), .reg_addr_i(reg_addr_i), .reg_wdata_i(reg_wdata_i), .reg_rdata_o(reg_rdata_o),
		.strap_fast_enable_i(s_en), .strap_source_select_i(s_sel), .strap_equalization_i(s_eq),
		.strap_preemphasis_field_i(s_pe), .strap_output_termination_i(s_oto), .strap_output_current_i(s_ocl),
		.strap_mode_o(strap_mode), .fast_channel_enable_o(fen), .fast_source_select_o(fsel),
		.fast_route_o(froute), .low_speed_enable_o(len), .low_speed_source_select_o(lsel),
		.low_speed_common_port_o(lport), .input_termination_a_o(term_a), .input_termination_b_o(term_b),
		.input_termination_c_o(term_c), .input_termination_d_o(term_d), .input_equalization_level_a_o(eq_a),
		.input_equalization_level_b_o(eq_b), .input_equalization_level_c_o(eq_c),
		.input_equalization_level_d_o(eq_d), .output_preemphasis_level_o(pe),
		.output_termination_on_o(oterm), .output_current_level_o(ocur));
	// 200 MHz clock
	initial begin
		sys_clk_i = 1'b0;
		forever #2.5 sys_clk_i = ~sys_clk_i;
	end
	// counts and verdict
	task automatic summarize;
		$display("checks %0d mismatches %0d", num_checks, error_cnt);
		if (error_cnt == 0 && num_checks > 0) begin
			$display("All checks passed");
		end else begin
			$display("Checks failed");
		end
		$finish;
	endtask : summarize
	// hang guard
	always @(posedge sys_clk_i) begin
		cycle_cnt <= cycle_cnt + 1;
		if (cycle_cnt == 3000) begin
			error_cnt++;
			summarize();
		end
	end
	// value compare
	task automatic chk(input logic [15:0] got, input logic [15:0] exp);
		num_checks++;
		if (got !== exp) begin
			error_cnt++;
			$display("[ERR] %0t got %h exp %h", $time, got, exp);
		end
	endtask : chk
	// one-cycle write strobe
	task automatic wr(input logic [7:0] a, input logic [7:0] d);
		@(posedge sys_clk_i);
		reg_wr_i <= 1'b1;
		reg_addr_i <= a;
		reg_wdata_i <= d;
		@(posedge sys_clk_i);
		reg_wr_i <= 1'b0;
	endtask : wr
	// one-cycle read strobe, data compared after the taking edge
	task automatic rd(input logic [7:0] a, input logic [7:0] exp);
		@(posedge sys_clk_i);
		reg_rd_i <= 1'b1;
		reg_addr_i <= a;
		@(posedge sys_clk_i);
		reg_rd_i <= 1'b0;
		#1;
		chk(reg_rdata_o, exp);
	endtask : rd
	// let n edges pass, then settle
	task automatic tick(input int n);
		repeat (n) @(posedge sys_clk_i);
		#1;
	endtask : tick
	// main sequence
	initial begin
		rst_i = 1'b1;
		reg_wr_i = 1'b0;
		reg_rd_i = 1'b0;
		reg_addr_i = 8'h00;
		reg_wdata_i = 8'h00;
		repeat (20) @(posedge sys_clk_i);
		rst_i <= 1'b0;
		tick(3);
		chk({strap_mode, fen, len, lsel, fsel}, {1'b1, S_EN, 1'b1, S_SEL, S_SEL});
		chk({eq_a, eq_b, eq_c, eq_d}, {16{S_EQ}});
		chk({term_a, term_b, term_c, term_d}, 16'hffff);
		chk({pe, oterm, ocur}, {S_PE, S_OTO, S_OCL});
		rd(VSWC_OFS_FAST_MODES, {1'b0, S_EN, 4'h0, S_SEL});
		chk(strap_mode, 1'b0);
		rd(VSWC_OFS_EQ_CD, {8{S_EQ}});
		$display("test straps done");
		// second reset, access at the first edge skips the straps
		@(posedge sys_clk_i);
		rst_i <= 1'b1;
		repeat (20) @(posedge sys_clk_i);
		rst_i <= 1'b0;
		reg_rd_i <= 1'b1;
		reg_addr_i <= 8'hff;
		@(posedge sys_clk_i);
		reg_rd_i <= 1'b0;
		#1;
		chk({strap_mode, reg_rdata_o}, {1'b0, VSWC_RDATA_UNMAPPED});
		foreach (ofs[i]) rd(ofs[i], rvl[i]);
		$display("test reset values done");
		foreach (ofs[i]) wr(ofs[i], 8'hff);
		wr(8'h30, 8'h5a);
		foreach (ofs[i]) rd(ofs[i], msk[i]);
		rd(8'h30, VSWC_RDATA_UNMAPPED);
		$display("test masks done");
		for (int i = 0; i < 4; i++) begin
			wr(VSWC_OFS_AUX_MODES, 8'h40 | 8'(i));
			wr(VSWC_OFS_FAST_MODES, 8'h40 | 8'(i));
			wr(VSWC_OFS_TX_SETTINGS, {4'h0, i[1:0], i[0], ~i[0]});
			tick(1);
			chk({lport, froute}, {4'h1 << i, 4'h1 << i});
			chk({pe, oterm, ocur}, {i[1:0], i[0], ~i[0]});
		end
		wr(VSWC_OFS_AUX_MODES, 8'h00);
		wr(VSWC_OFS_FAST_MODES, 8'h03);
		tick(1);
		chk({len, fen, lport, froute}, 16'h0);
		$display("test decode done");
		wr(VSWC_OFS_EQ_AB, 8'h01);
		wr(VSWC_OFS_EQ_CD, 8'h01);
		tick(1);
		chk({eq_a, eq_b, eq_c, eq_d}, 16'h0180);
		wr(VSWC_OFS_EQ_AB, 8'h10);
		wr(VSWC_OFS_EQ_CD, 8'h10);
		tick(1);
		chk({eq_a, eq_b, eq_c, eq_d}, 16'h1008);
		$display("test equalizer map done");
		wr(VSWC_OFS_RX_SETTINGS, 8'h01);
		wr(VSWC_OFS_PULSE_AB, 8'h01);
		wr(VSWC_OFS_PULSE_CD, 8'h01);
		tick(PULSE_N + 5);
		wr(VSWC_OFS_FAST_MODES, 8'h41);
		tick(2);
		chk({term_a, term_b, term_c, term_d}, 16'hfe7f);
		tick(10);
		wr(VSWC_OFS_FAST_MODES, 8'h42);
		tick(15);
		chk({term_a, term_b, term_c, term_d}, 16'hfe7f);
		tick(15);
		chk({term_a, term_b, term_c, term_d}, 16'hffff);
		wr(VSWC_OFS_RX_SETTINGS, 8'h00);
		tick(2);
		chk({term_a, term_b, term_c, term_d}, 16'h0000);
		$display("test termination pulse done");
		summarize();
	end
endmodule : tb_vswc_config_regs
